//--- rtl/sbrp_params.svh
// constants for the synchronous block memory port: sizes, offsets, fields, reset values
`ifndef SBRP_PARAMS_SVH
`define SBRP_PARAMS_SVH
// array geometry: 512 words of four 9-bit lanes
`define SBRP_DW 36
`define SBRP_AW 9
`define SBRP_DEPTH 512
`define SBRP_LANES 4
`define SBRP_LW 9
// apb register byte offsets
`define SBRP_CTRL_OFF 12'h000
`define SBRP_PLO_OFF 12'h004
`define SBRP_PHI_OFF 12'h008
`define SBRP_STAT_OFF 12'h00c
// control register fields
`define SBRP_CTRL_MODE_LSB 0
`define SBRP_CTRL_OREG_BIT 2
`define SBRP_CTRL_WID_LSB 3
// reset values
`define SBRP_MODE_RST 2'h0
`define SBRP_OREG_RST 1'h0
`define SBRP_WID_RST 2'h0
`define SBRP_PLO_RST 32'h00000000
`define SBRP_PHI_RST 4'h0
`define SBRP_LATCH_RST 36'h000000000
`endif

//--- rtl/sbrp_pkg.sv
// types shared by the synchronous block memory port
package sbrp_pkg;
  // output behaviour during a write
  typedef enum logic [1:0] {
    SBRP_WR_FIRST = 2'b00,
    SBRP_RD_FIRST = 2'b01,
    SBRP_NO_CHANGE = 2'b10
  } sbrp_mode_t;
  // strobe sharing per configured port width
  typedef enum logic [1:0] {
    SBRP_X36 = 2'b00,
    SBRP_X18 = 2'b01,
    SBRP_X9 = 2'b10
  } sbrp_width_t;
  // operation performed at the last clock edge
  typedef enum logic [1:0] {
    SBRP_OP_IDLE = 2'b00,
    SBRP_OP_READ = 2'b01,
    SBRP_OP_WRITE = 2'b10,
    SBRP_OP_PRESET = 2'b11
  } sbrp_op_t;
endpackage

//--- rtl/sbrp_mem.sv
// storage array of the block memory port, combinational read, clocked whole-word write
`timescale 1ns/1ps
`include "sbrp_params.svh"
module sbrp_mem (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [`SBRP_AW-1:0] addr,
  input wire logic [`SBRP_DW-1:0] wdata,
  // read side
  output logic [`SBRP_DW-1:0] rdata
);
  logic [`SBRP_DW-1:0] mem [0:`SBRP_DEPTH-1];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wdata;
    end
  end

  // old word, used by reads, lane merges and read-first output
  assign rdata = mem[addr];
endmodule

//--- rtl/sbrp_top.sv
// synchronous block memory port with apb configuration and optional output register
// Behaviour
// - read leaves addressed word untouched
// - enabled read edge shows stored word after edge
// - write-first stores and outputs new word
// - preset loads configured value into latches
// - preset never writes, ignores address and data
// - disabled edge: no read, write, preset
// - disabled edge holds array and latches
// - output register adds one cycle latency
// - output register loads only when gated
// - strobes gate byte lanes per width
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "sbrp_params.svh"
module sbrp_top
  import sbrp_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // user memory port
  input wire logic port_en,
  input wire logic [`SBRP_LANES-1:0] write_strobe,
  input wire logic [`SBRP_AW-1:0] addr,
  input wire logic [`SBRP_DW-1:0] write_word,
  input wire logic sync_output_preset,
  input wire logic output_reg_clock_gate,
  output logic [`SBRP_DW-1:0] read_word
);

  // ****************************************
  // helpers
  // ****************************************

  // map user strobes onto the four lanes
  function automatic logic [3:0] lane_map(input logic [1:0] wid, input logic [3:0] we);
    logic [3:0] m;
    m = 4'h0;
    if (wid == SBRP_X36)
      m = we;
    else if (wid == SBRP_X18)
      m = {we[1], we[0], we[1], we[0]};
    else
      m = {4{we[0]}};
    return m;
  endfunction

  // overlay new lanes onto the old word
  function automatic logic [`SBRP_DW-1:0] merge(input logic [`SBRP_DW-1:0] old_w,
    input logic [`SBRP_DW-1:0] new_w, input logic [3:0] ln);
    logic [`SBRP_DW-1:0] r;
    r = old_w;
    for (int i = 0; i < `SBRP_LANES; i++)
    begin
      if (ln[i])
        r[i*`SBRP_LW +: `SBRP_LW] = new_w[i*`SBRP_LW +: `SBRP_LW];
    end
    return r;
  endfunction

  // ****************************************
  // configuration registers
  // ****************************************

  logic [1:0] mode_ff;
  logic oreg_ff;
  logic [1:0] width_ff;
  logic [31:0] preset_lo_ff;
  logic [3:0] preset_hi_ff;
  logic [1:0] last_op_ff;
  logic [`SBRP_DW-1:0] latch_ff;
  logic [`SBRP_DW-1:0] nxt_latch;
  logic [`SBRP_DW-1:0] mem_rd;
  logic [`SBRP_DW-1:0] merged;
  logic [`SBRP_DW-1:0] output_preset_value;
  logic [3:0] lanes;
  logic do_preset;
  logic do_write;
  logic do_read;
  logic apb_fire;
  logic [31:0] rd_val;
  logic rd_hit;

  // a write lands only at the edge where pready is seen high
  assign apb_fire = psel & penable & pready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= `SBRP_MODE_RST;
      oreg_ff <= `SBRP_OREG_RST;
      width_ff <= `SBRP_WID_RST;
      preset_lo_ff <= `SBRP_PLO_RST;
      preset_hi_ff <= `SBRP_PHI_RST;
    end
    else if (apb_fire && pwrite)
    begin
      if (paddr == `SBRP_CTRL_OFF)
      begin
        mode_ff <= pwdata[`SBRP_CTRL_MODE_LSB +: 2];
        oreg_ff <= pwdata[`SBRP_CTRL_OREG_BIT];
        width_ff <= pwdata[`SBRP_CTRL_WID_LSB +: 2];
      end
      else if (paddr == `SBRP_PLO_OFF)
        preset_lo_ff <= pwdata;
      else if (paddr == `SBRP_PHI_OFF)
        preset_hi_ff <= pwdata[3:0];
    end
  end

  // read mux; status is read-only and writes to it are dropped quietly
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (paddr == `SBRP_CTRL_OFF)
      rd_val = {27'h0000000, width_ff, oreg_ff, mode_ff};
    else if (paddr == `SBRP_PLO_OFF)
      rd_val = preset_lo_ff;
    else if (paddr == `SBRP_PHI_OFF)
      rd_val = {28'h0000000, preset_hi_ff};
    else if (paddr == `SBRP_STAT_OFF)
      rd_val = {30'h00000000, last_op_ff};
    else
      rd_hit = 1'b0;
  end

  // one wait state so that every apb output leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= ~rd_hit;
    end
    else
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // memory port datapath
  // ****************************************

  assign output_preset_value = {preset_hi_ff, preset_lo_ff};
  assign lanes = lane_map(width_ff, write_strobe);
  // enable low blocks every operation
  assign do_preset = port_en & sync_output_preset;
  // preset wins over a write so the array stays untouched
  assign do_write = port_en & ~sync_output_preset & (|lanes);
  assign do_read = port_en & ~sync_output_preset & ~(|lanes);
  assign merged = merge(mem_rd, write_word, lanes);

  sbrp_mem u_mem (
    .clk(pclk),
    .wr_en(do_write),
    .addr(addr),
    .wdata(merged),
    .rdata(mem_rd)
  );

  // next output latch value by operation and write mode
  always_comb
  begin
    nxt_latch = latch_ff;
    if (do_preset)
      nxt_latch = output_preset_value;
    else if (do_read)
      nxt_latch = mem_rd;
    else if (do_write)
    begin
      case (mode_ff)
        SBRP_WR_FIRST: nxt_latch = merged;
        SBRP_RD_FIRST: nxt_latch = mem_rd;
        default: nxt_latch = latch_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_ff <= `SBRP_LATCH_RST;
    else
      latch_ff <= nxt_latch;
  end

  // without the register the pin follows the latch at the same edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_word <= `SBRP_LATCH_RST;
    else if (!oreg_ff)
      read_word <= nxt_latch;
    else if (output_reg_clock_gate)
      read_word <= latch_ff;
  end

  // last operation, visible in the status register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_op_ff <= SBRP_OP_IDLE;
    else if (do_preset)
      last_op_ff <= SBRP_OP_PRESET;
    else if (do_write)
      last_op_ff <= SBRP_OP_WRITE;
    else if (do_read)
      last_op_ff <= SBRP_OP_READ;
    else
      last_op_ff <= SBRP_OP_IDLE;
  end

  // ****************************************
  // assertions
  // ****************************************

  property p_read_keeps;
    @(posedge pclk) disable iff (!presetn)
    do_read ##1 (addr == $past(addr)) |-> mem_rd === $past(mem_rd);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read changed word");

  property p_read_data;
    @(posedge pclk) disable iff (!presetn)
    do_read |=> latch_ff == $past(mem_rd);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_wr_first;
    @(posedge pclk) disable iff (!presetn)
    (do_write && mode_ff == SBRP_WR_FIRST) ##1 (addr == $past(addr))
      |-> latch_ff == $past(merged) && mem_rd == latch_ff;
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("write-first wrong");

  property p_preset;
    @(posedge pclk) disable iff (!presetn)
    do_preset |=> latch_ff == $past(output_preset_value);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");

  property p_preset_no_write;
    @(posedge pclk) disable iff (!presetn)
    do_preset ##1 (addr == $past(addr)) |-> mem_rd === $past(mem_rd);
  endproperty
  a_preset_no_write: assert property (p_preset_no_write) else $error("preset wrote");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    // status must report no operation for a disabled edge
    !port_en |=> last_op_ff == SBRP_OP_IDLE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("op while disabled");

  property p_disable_hold;
    @(posedge pclk) disable iff (!presetn)
    // case equality: a never-written word must stay unknown, not count as a change
    !port_en ##1 (addr == $past(addr)) |-> $stable(latch_ff) && mem_rd === $past(mem_rd);
  endproperty
  a_disable_hold: assert property (p_disable_hold) else $error("disable changed state");

  property p_oreg_latency;
    @(posedge pclk) disable iff (!presetn)
    (oreg_ff && output_reg_clock_gate) ##1 oreg_ff |-> read_word == $past(latch_ff);
  endproperty
  a_oreg_latency: assert property (p_oreg_latency) else $error("register latency wrong");

  property p_no_oreg;
    @(posedge pclk) disable iff (!presetn)
    !oreg_ff ##1 !oreg_ff |-> read_word == latch_ff;
  endproperty
  a_no_oreg: assert property (p_no_oreg) else $error("unregistered output lags");

  property p_rd_first;
    @(posedge pclk) disable iff (!presetn)
    do_write && mode_ff == SBRP_RD_FIRST |=> latch_ff == $past(mem_rd);
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("read-first wrong");

  property p_no_change;
    @(posedge pclk) disable iff (!presetn)
    do_write && mode_ff == SBRP_NO_CHANGE |=> $stable(latch_ff);
  endproperty
  a_no_change: assert property (p_no_change) else $error("no-change moved");

  property p_gate_hold;
    @(posedge pclk) disable iff (!presetn)
    oreg_ff && !output_reg_clock_gate |=> $stable(read_word);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("register loaded ungated");

  property p_lane_x36;
    @(posedge pclk) disable iff (!presetn)
    (do_write && width_ff == SBRP_X36 && write_strobe == 4'b0101) ##1 (addr == $past(addr))
      |-> mem_rd[35:27] === $past(mem_rd[35:27])
        && mem_rd[26:18] === $past(write_word[26:18])
        && mem_rd[17:9] === $past(mem_rd[17:9])
        && mem_rd[8:0] === $past(write_word[8:0]);
  endproperty
  a_lane_x36: assert property (p_lane_x36) else $error("lane gating wrong");
endmodule

//--- verification/sbrp_user_model.sv
// user fabric model that drives the memory port of the block
`timescale 1ns/1ps
`include "sbrp_params.svh"
module sbrp_user_model (
  // clock
  input wire logic pclk,
  // memory port drive
  output logic port_en,
  output logic [`SBRP_LANES-1:0] write_strobe,
  output logic [`SBRP_AW-1:0] addr,
  output logic [`SBRP_DW-1:0] write_word,
  output logic sync_output_preset,
  output logic output_reg_clock_gate
);
  // set by the bench while the output register is in use
  logic oreg_on = 1'b0;
  // idle at time zero, register gate open
  initial
  begin
    port_en = 1'b0;
    write_strobe = 4'h0;
    addr = 9'h000;
    write_word = 36'h0;
    sync_output_preset = 1'b0;
    output_reg_clock_gate = 1'b1;
  end
  // one request, held across exactly one taken edge
  task automatic op(input logic en, input logic [3:0] st, input logic [8:0] a,
                    input logic [35:0] w, input logic pre, input logic g);
    @(posedge pclk);
    port_en <= en;
    write_strobe <= st;
    addr <= a;
    write_word <= w;
    sync_output_preset <= pre & ~oreg_on;
    output_reg_clock_gate <= g;
    @(posedge pclk);
    // enable drops while the address holds, so the word can be watched after the edge
    port_en <= 1'b0;
    write_strobe <= 4'h0;
    write_word <= ~w;
    sync_output_preset <= 1'b0;
  endtask
endmodule

//--- verification/test_sbrp_top.sv
// self-checking bench for the block memory port
`timescale 1ns/1ps
`include "sbrp_params.svh"
module test_sbrp_top
  import sbrp_pkg::*;
;
  // ****************
  // signals
  // ****************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, rng = 32'hb556e9b2;
  logic pready, pslverr, er, pen, pre, gate;
  logic [3:0] ws;
  logic [8:0] ad;
  logic [35:0] ww, rword, cur = 36'h0, pv = 36'h0;
  logic [35:0] mem [0:511];
  logic [35:0] q [$];
  logic [8:0] al [3];
  logic [1:0] md = 2'h0;
  logic [1:0] wd = 2'h0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  // clock
  always #25 pclk = ~pclk;
  sbrp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_en(pen), .write_strobe(ws), .addr(ad), .write_word(ww),
    .sync_output_preset(pre), .output_reg_clock_gate(gate), .read_word(rword));
  sbrp_user_model u_usr (.pclk(pclk), .port_en(pen), .write_strobe(ws), .addr(ad),
    .write_word(ww), .sync_output_preset(pre), .output_reg_clock_gate(gate));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // lanes touched by a strobe pattern under the current width
  function automatic logic [35:0] lmask(input logic [3:0] s);
    logic [3:0] l;
    l = (wd == 2'h0) ? s : (wd == 2'h1) ? {s[1], s[0], s[1], s[0]} : {4{s[0]}};
    for (int i = 0; i < 4; i++)
      lmask[9*i+:9] = {9{l[i]}};
  endfunction
  task automatic check(input string nm, input logic [35:0] s, input logic [35:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // apb transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // port request plus the note of what read_word must show afterwards
  task automatic op(input logic en, input logic [3:0] st, input logic [8:0] a,
                    input logic [35:0] w, input logic p);
    logic [35:0] m, old;
    m = lmask(st);
    u_usr.op(en, st, a, w, p, 1'b1);
    if (!en)
      cur = cur;
    else if (p)
      cur = pv;
    else if (|st)
    begin
      old = mem[a];
      mem[a] = (old & ~m) | (w & m);
      cur = (md == 2'h0) ? mem[a] : (md == 2'h1) ? old : cur;
    end
    else
      cur = mem[a];
    q.push_back(cur);
  endtask
  // watcher: oldest note against what the port shows
  always @(negedge pclk)
    if (q.size() > 0)
      check("read_word", rword, q.pop_front());
  // hang guard, far above the roughly 120 cycles needed
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check("read_word", rword, 36'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check("reg", {4'h0, rd}, 36'h0);
    end
    apb(1'b1, 12'h010, 32'h1);
    check("slverr", {35'h0, er}, 36'h1);
    al = '{9'h000, 9'h1ff, rng[8:0]};
    for (int i = 0; i < 3; i++)
    begin
      rng = lfsr(rng);
      op(1'b1, 4'hf, al[i], {rng[3:0], rng}, 1'b0);
      op(1'b1, 4'h0, al[i], 36'h0, 1'b0);
      op(1'b1, 4'h0, al[i], 36'h0, 1'b0);
    end
    for (int k = 0; k < 3; k++)
    begin
      wd = 2'(k);
      apb(1'b1, `SBRP_CTRL_OFF, {27'h0, wd, 3'h0});
      rng = lfsr(rng);
      op(1'b1, 4'b0101, al[0], {rng[3:0], rng}, 1'b0);
      op(1'b1, 4'h0, al[0], 36'h0, 1'b0);
    end
    wd = 2'h0;
    rng = lfsr(rng);
    apb(1'b1, `SBRP_PLO_OFF, rng);
    apb(1'b1, `SBRP_PHI_OFF, {28'h0, rng[7:4]});
    pv = {rng[7:4], rng};
    op(1'b1, 4'hf, al[1], ~pv, 1'b1);
    op(1'b1, 4'h0, al[1], 36'h0, 1'b0);
    op(1'b0, 4'hf, al[0], pv, 1'b1);
    op(1'b1, 4'h0, al[0], 36'h0, 1'b0);
    for (int k = 1; k < 3; k++)
    begin
      md = 2'(k);
      apb(1'b1, `SBRP_CTRL_OFF, {30'h0, md});
      rng = lfsr(rng);
      op(1'b1, 4'hf, al[2], {rng[3:0], rng}, 1'b0);
    end
    md = 2'h0;
    apb(1'b1, `SBRP_STAT_OFF, 32'h3);
    apb(1'b0, `SBRP_STAT_OFF, 32'h0);
    check("stat", {4'h0, rd}, 36'h0);
    apb(1'b1, `SBRP_CTRL_OFF, 32'h4);
    u_usr.oreg_on = 1'b1;
    u_usr.op(1'b1, 4'h0, al[0], 36'h0, 1'b0, 1'b1);
    q.push_back(cur);
    @(posedge pclk);
    q.push_back(mem[al[0]]);
    u_usr.op(1'b1, 4'h0, al[1], 36'h0, 1'b0, 1'b0);
    repeat (2) @(posedge pclk);
    q.push_back(mem[al[0]]);
    u_usr.op(1'b0, 4'h0, 9'h000, 36'h0, 1'b0, 1'b1);
    q.push_back(mem[al[1]]);
    repeat (2) @(negedge pclk);
    give_verdict();
  end
endmodule
